/* File: core/capobj_pkg.sv */
// shared types and constants for the capability object codec
package capobj_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  typedef enum logic [1:0] {SVC_DIR, SVC_FCTL, SVC_CFG, SVC_ZONE} svc_t;

  // service type code and subtype of each object
  localparam logic [7:0] TYPE_DIR = 8'hfc;
  localparam logic [7:0] SUB_DIR = 8'h02;
  localparam logic [7:0] TYPE_FCTL = 8'hfd;
  localparam logic [7:0] SUB_FCTL = 8'h00;
  localparam logic [7:0] TYPE_MGMT = 8'hfa;
  localparam logic [7:0] SUB_CFG = 8'h01;
  localparam logic [7:0] SUB_ZONE = 8'h03;

  // defined bits of each support-flag word
  localparam logic [31:0] MASK_DIR = 32'h0000001f;
  localparam logic [31:0] MASK_FCTL = 32'h00000001;
  localparam logic [31:0] MASK_CFG = 32'h0000000f;
  localparam logic [31:0] MASK_ZONE = 32'h000003ff;

  // object layout
  localparam logic [3:0] HDR_RSV = 4'h2;
  localparam logic [3:0] HDR_CNT = 4'h3;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [2:0] ENT_LAST = 3'h7;
  localparam logic [3:0] TX_LAST_IDX = 4'hb;
  localparam logic [7:0] TX_ENTRIES = 8'h01;
  localparam logic [7:0] RSV_BYTE = 8'h00;

  // field positions in the flag words
  localparam int unsigned NS_FMT_LSB = 0;
  localparam int unsigned NS_ZERO_ACC = 4;
  localparam int unsigned FC_RSCN = 0;
  localparam int unsigned CFG_CLS_LSB = 0;
  localparam int unsigned ZN_CAPABLE = 0;
  localparam int unsigned ZN_ENHANCED = 1;
  localparam int unsigned ZN_RESTRICT = 2;
  localparam int unsigned ZN_DENY_DEF = 3;
  localparam int unsigned ZN_DB_CAP = 4;
  localparam int unsigned ZN_DB_ON = 5;
  localparam int unsigned ZN_ACT_DIR = 6;
  localparam int unsigned ZN_HARD = 7;
  localparam int unsigned ZN_SEC_SUP = 8;
  localparam int unsigned ZN_SEC_EN = 9;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_L_DIR = 8'h04;
  localparam logic [7:0] REG_L_DIRV = 8'h08;
  localparam logic [7:0] REG_L_FCTL = 8'h0c;
  localparam logic [7:0] REG_L_FCTLV = 8'h10;
  localparam logic [7:0] REG_L_CFG = 8'h14;
  localparam logic [7:0] REG_L_ZONE = 8'h18;
  localparam logic [7:0] REG_P_DIR = 8'h20;
  localparam logic [7:0] REG_P_DIRV = 8'h24;
  localparam logic [7:0] REG_P_FCTL = 8'h28;
  localparam logic [7:0] REG_P_FCTLV = 8'h2c;
  localparam logic [7:0] REG_P_CFG = 8'h30;
  localparam logic [7:0] REG_P_ZONE = 8'h34;
  localparam logic [7:0] REG_STATUS = 8'h38;

  // control and status bits
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_SVC_LSB = 1;
  localparam int unsigned ST_BUSY = 4;
  localparam int unsigned ST_UNK = 5;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } beat_t;

  typedef struct packed {
    logic [3:0] ns_fmt;
    logic ns_zero_acc;
    logic fc_rscn;
    logic [3:0] cfg_cls;
  } peer_caps_t;

  typedef struct packed {
    logic sec_en;
    logic sec_sup;
    logic hard;
    logic act_dir;
    logic db_on;
    logic db_cap;
    logic deny_def;
    logic restrict_merge;
    logic enhanced;
    logic capable;
  } zone_flags_t;
endpackage

/* File: core/capobj_entry_asm.sv */
// gathers eight received bytes into one capability entry
`timescale 1ns/100ps
module capobj_entry_asm
  import capobj_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic [63:0] o_entry,
  output logic o_done
);
  logic [2:0] idx_q;
  logic [63:0] acc_q;

  // RQ2 eight byte entry
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idx_q <= '0;
      acc_q <= '0;
      o_done <= 1'b0;
      o_entry <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_valid) begin
        acc_q <= {acc_q[55:0], i_byte};
        idx_q <= idx_q + 3'h1;
        if (idx_q == ENT_LAST) begin
          o_entry <= {acc_q[55:0], i_byte};
          o_done <= 1'b1;
        end
      end
      // a cut object drops a partial entry, but an entry whose eighth byte ends it still completes
      if (i_clear) begin
        idx_q <= '0;
      end
    end
  end
endmodule // capobj_entry_asm

/* File: core/capobj_codec.sv */
// capability object codec: builds local objects, parses peer objects
// Behaviour
// RQ1: object header is type code, subtype, reserved byte, entry count.
// RQ2: each entry following the header is exactly eight bytes.
// RQ3: directory object uses type FCh subtype 02h, flags then vendor word.
// RQ4: directory flag bits 0-3 accept entry formats 00h to 03h.
// RQ5: directory bit 4 is zero-length accept support; bits 5-31 reserved.
// RQ6: fabric controller object uses type FDh subtype 00h, flags then vendor.
// RQ7: fabric controller bit 0 accepts change notifications; rest reserved.
// RQ8: vendor flag words pass through without decoding.
// RQ9: configuration server object uses FAh subtype 01h, flags then reserved.
// RQ10: configuration bits 0-3 give command class support; bits 4-31 reserved.
// RQ11: zone server object uses FAh subtype 03h, flags then reserved.
// RQ12: zoning bit 0 is enhanced mode capable.
// RQ13: zoning bit 1 is enhanced mode operating.
// RQ14: zoning bit 2 is restrict merge policy when one.
// RQ15: zoning bit 3 denies default zone traffic when one.
// RQ16: zoning bit 4 is zone set database capable.
// RQ17: zoning bit 5 is zone set database kept now.
// RQ18: zoning bit 6 is activate-direct support.
// RQ19: zoning bit 7 is hard zoning support.
// RQ20: zoning bits 8 and 9 are secure zoning support, enable; rest reserved.
// RQ21: reserved bits and bytes sent as zero and ignored on receive.
`timescale 1ns/100ps
module capobj_codec
  import capobj_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DATA_W-1:0] O_RDATA,
  output beat_t O_TX_BEAT,
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire beat_t I_RX_BEAT,
  input wire logic I_RX_VALID,
  output peer_caps_t O_PEER_CAPS,
  output zone_flags_t O_PEER_ZONE
);
  typedef enum logic {RX_HDR, RX_ENT} rx_state_t;

  function automatic logic [7:0] svc_type(input svc_t s);
    case (s)
      SVC_DIR: svc_type = TYPE_DIR;
      SVC_FCTL: svc_type = TYPE_FCTL;
      default: svc_type = TYPE_MGMT;
    endcase
  endfunction

  function automatic logic [7:0] svc_sub(input svc_t s);
    case (s)
      SVC_DIR: svc_sub = SUB_DIR;
      SVC_FCTL: svc_sub = SUB_FCTL;
      SVC_CFG: svc_sub = SUB_CFG;
      default: svc_sub = SUB_ZONE;
    endcase
  endfunction

  function automatic logic [31:0] svc_mask(input svc_t s);
    case (s)
      SVC_DIR: svc_mask = MASK_DIR;
      SVC_FCTL: svc_mask = MASK_FCTL;
      SVC_CFG: svc_mask = MASK_CFG;
      default: svc_mask = MASK_ZONE;
    endcase
  endfunction

  // local service state
  logic [31:0] l_dir_q, l_dirv_q, l_fctl_q, l_fctlv_q, l_cfg_q, l_zone_q;
  // peer service state
  logic [31:0] p_dir_q, p_dirv_q, p_fctl_q, p_fctlv_q, p_cfg_q, p_zone_q;
  logic [3:0] p_valid_q;
  logic unk_q;

  logic wr_go;
  logic tx_busy;
  svc_t go_svc;
  logic [7:0] go_type;
  logic [95:0] go_frame;
  logic [31:0] status_w;

  assign tx_busy = O_TX_VALID;
  assign go_svc = svc_t'(I_WDATA[CTRL_SVC_LSB +: 2]);
  assign go_type = svc_type(go_svc);
  assign wr_go = I_WR && (I_ADDR == REG_CTRL) && I_WDATA[CTRL_GO];
  assign status_w = {26'h0, unk_q, tx_busy, p_valid_q};

  // RQ21 reserved bits cleared
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      l_dir_q <= '0;
      l_dirv_q <= '0;
      l_fctl_q <= '0;
      l_fctlv_q <= '0;
      l_cfg_q <= '0;
      l_zone_q <= '0;
    end else if (I_WR) begin
      case (I_ADDR)
        REG_L_DIR: l_dir_q <= I_WDATA & MASK_DIR;
        REG_L_DIRV: l_dirv_q <= I_WDATA;
        REG_L_FCTL: l_fctl_q <= I_WDATA & MASK_FCTL;
        REG_L_FCTLV: l_fctlv_q <= I_WDATA;
        REG_L_CFG: l_cfg_q <= I_WDATA & MASK_CFG;
        REG_L_ZONE: l_zone_q <= I_WDATA & MASK_ZONE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_RDATA <= '0;
    end else if (I_RD) begin
      case (I_ADDR)
        REG_L_DIR: O_RDATA <= l_dir_q;
        REG_L_DIRV: O_RDATA <= l_dirv_q;
        REG_L_FCTL: O_RDATA <= l_fctl_q;
        REG_L_FCTLV: O_RDATA <= l_fctlv_q;
        REG_L_CFG: O_RDATA <= l_cfg_q;
        REG_L_ZONE: O_RDATA <= l_zone_q;
        REG_P_DIR: O_RDATA <= p_dir_q;
        REG_P_DIRV: O_RDATA <= p_dirv_q;
        REG_P_FCTL: O_RDATA <= p_fctl_q;
        REG_P_FCTLV: O_RDATA <= p_fctlv_q;
        REG_P_CFG: O_RDATA <= p_cfg_q;
        REG_P_ZONE: O_RDATA <= p_zone_q;
        REG_STATUS: O_RDATA <= status_w;
        default: O_RDATA <= '0;
      endcase
    end else begin
      O_RDATA <= '0;
    end
  end

  // transmit: one object of one entry per request
  always_comb begin
    go_frame = '0;
    // RQ1 header layout
    go_frame[95:64] = {go_type, svc_sub(go_svc), RSV_BYTE, TX_ENTRIES};
    case (go_svc)
      // RQ3 directory entry
      SVC_DIR: go_frame[63:0] = {l_dir_q, l_dirv_q};
      // RQ6 controller entry
      SVC_FCTL: go_frame[63:0] = {l_fctl_q, l_fctlv_q};
      // RQ9 config entry
      SVC_CFG: go_frame[63:0] = {l_cfg_q, 32'h0};
      // RQ11 zoning entry
      default: go_frame[63:0] = {l_zone_q, 32'h0};
    endcase
  end

  logic [87:0] tx_rest_q;
  logic [3:0] tx_idx_q;

  // RQ2 twelve byte object
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_TX_VALID <= 1'b0;
      O_TX_BEAT <= '0;
      tx_rest_q <= '0;
      tx_idx_q <= '0;
    end else if (wr_go && !tx_busy) begin
      O_TX_VALID <= 1'b1;
      O_TX_BEAT <= '{data: go_frame[95:88], last: 1'b0};
      tx_rest_q <= go_frame[87:0];
      tx_idx_q <= '0;
    end else if (O_TX_VALID && I_TX_READY) begin
      if (O_TX_BEAT.last) begin
        O_TX_VALID <= 1'b0;
        O_TX_BEAT <= '0;
      end else begin
        O_TX_BEAT <= '{data: tx_rest_q[87:80], last: tx_idx_q == TX_LAST_IDX - 4'h1};
        tx_rest_q <= {tx_rest_q[79:0], 8'h00};
        tx_idx_q <= tx_idx_q + 4'h1;
      end
    end
  end

  // receive parser
  rx_state_t rx_state_q;
  logic [1:0] hdr_idx_q;
  logic [7:0] rx_type_q, rx_sub_q, ent_left_q;
  logic [2:0] ent_byte_q;
  logic ent_valid, ent_done, ent_clear;
  logic [63:0] ent_w;

  assign ent_valid = I_RX_VALID && (rx_state_q == RX_ENT);
  assign ent_clear = I_RX_VALID && I_RX_BEAT.last;

  capobj_entry_asm u_asm (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESET_N),
    .i_clear(ent_clear),
    .i_valid(ent_valid),
    .i_byte(I_RX_BEAT.data),
    .o_entry(ent_w),
    .o_done(ent_done)
  );

  // RQ1 header parse
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      rx_state_q <= RX_HDR;
      hdr_idx_q <= '0;
      rx_type_q <= '0;
      rx_sub_q <= '0;
      ent_left_q <= '0;
      ent_byte_q <= '0;
    end else if (I_RX_VALID) begin
      case (rx_state_q)
        RX_HDR: begin
          hdr_idx_q <= hdr_idx_q + 2'h1;
          case (hdr_idx_q)
            2'h0: rx_type_q <= I_RX_BEAT.data;
            2'h1: rx_sub_q <= I_RX_BEAT.data;
            // RQ21 reserved byte ignored
            2'h2: ;
            default: begin
              ent_left_q <= I_RX_BEAT.data;
              ent_byte_q <= '0;
              if (I_RX_BEAT.data != 8'h00 && !I_RX_BEAT.last) begin
                rx_state_q <= RX_ENT;
              end
            end
          endcase
          if (I_RX_BEAT.last) begin
            hdr_idx_q <= '0;
          end
        end
        // RQ2 count entry bytes
        RX_ENT: begin
          ent_byte_q <= ent_byte_q + 3'h1;
          if (ent_byte_q == ENT_LAST) begin
            ent_left_q <= ent_left_q - 8'h01;
          end
          if (I_RX_BEAT.last || (ent_byte_q == ENT_LAST && ent_left_q == 8'h01)) begin
            rx_state_q <= RX_HDR;
            hdr_idx_q <= '0;
          end
        end
        default: rx_state_q <= RX_HDR;
      endcase
    end
  end

  logic is_dir, is_fctl, is_cfg, is_zone, clr_unk;
  assign is_dir = rx_type_q == TYPE_DIR && rx_sub_q == SUB_DIR;
  assign is_fctl = rx_type_q == TYPE_FCTL && rx_sub_q == SUB_FCTL;
  assign is_cfg = rx_type_q == TYPE_MGMT && rx_sub_q == SUB_CFG;
  assign is_zone = rx_type_q == TYPE_MGMT && rx_sub_q == SUB_ZONE;
  assign clr_unk = I_WR && I_ADDR == REG_STATUS && I_WDATA[ST_UNK];

  // RQ21 reserved bits masked
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      p_dir_q <= '0;
      p_dirv_q <= '0;
      p_fctl_q <= '0;
      p_fctlv_q <= '0;
      p_cfg_q <= '0;
      p_zone_q <= '0;
      p_valid_q <= '0;
    end else if (ent_done) begin
      if (is_dir) begin
        // RQ8 vendor word passed
        p_dir_q <= ent_w[63:32] & svc_mask(SVC_DIR);
        p_dirv_q <= ent_w[31:0];
        p_valid_q[SVC_DIR] <= 1'b1;
      end
      if (is_fctl) begin
        // RQ8 vendor word passed
        p_fctl_q <= ent_w[63:32] & svc_mask(SVC_FCTL);
        p_fctlv_q <= ent_w[31:0];
        p_valid_q[SVC_FCTL] <= 1'b1;
      end
      if (is_cfg) begin
        p_cfg_q <= ent_w[63:32] & svc_mask(SVC_CFG);
        p_valid_q[SVC_CFG] <= 1'b1;
      end
      if (is_zone) begin
        p_zone_q <= ent_w[63:32] & svc_mask(SVC_ZONE);
        p_valid_q[SVC_ZONE] <= 1'b1;
      end
    end
  end

  // unknown object seen; a new one wins over the clear
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      unk_q <= 1'b0;
    end else if (ent_done && !(is_dir || is_fctl || is_cfg || is_zone)) begin
      unk_q <= 1'b1;
    end else if (clr_unk) begin
      unk_q <= 1'b0;
    end
  end

  // peer capability decode
  // RQ4 entry formats
  assign O_PEER_CAPS.ns_fmt = p_dir_q[NS_FMT_LSB +: 4];
  // RQ5 zero length accept
  assign O_PEER_CAPS.ns_zero_acc = p_dir_q[NS_ZERO_ACC];
  // RQ7 notification support
  assign O_PEER_CAPS.fc_rscn = p_fctl_q[FC_RSCN];
  // RQ10 command classes
  assign O_PEER_CAPS.cfg_cls = p_cfg_q[CFG_CLS_LSB +: 4];
  // RQ12 enhanced capable
  assign O_PEER_ZONE.capable = p_zone_q[ZN_CAPABLE];
  // RQ13 enhanced operating
  assign O_PEER_ZONE.enhanced = p_zone_q[ZN_ENHANCED];
  // RQ14 merge policy
  assign O_PEER_ZONE.restrict_merge = p_zone_q[ZN_RESTRICT];
  // RQ15 default zone
  assign O_PEER_ZONE.deny_def = p_zone_q[ZN_DENY_DEF];
  // RQ16 database capable
  assign O_PEER_ZONE.db_cap = p_zone_q[ZN_DB_CAP];
  // RQ17 database kept
  assign O_PEER_ZONE.db_on = p_zone_q[ZN_DB_ON];
  // RQ18 activate direct
  assign O_PEER_ZONE.act_dir = p_zone_q[ZN_ACT_DIR];
  // RQ19 hard zoning
  assign O_PEER_ZONE.hard = p_zone_q[ZN_HARD];
  // RQ20 secure zoning
  assign O_PEER_ZONE.sec_sup = p_zone_q[ZN_SEC_SUP];
  assign O_PEER_ZONE.sec_en = p_zone_q[ZN_SEC_EN];

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  sequence s_start;
    wr_go && !tx_busy;
  endsequence

  sequence s_hdr_first;
    O_TX_VALID && tx_idx_q == 4'h0;
  endsequence

  property p_tx_type;
    s_start |=> s_hdr_first ##0 (O_TX_BEAT.data == $past(go_type));
  endproperty
  a_tx_type: assert property (p_tx_type) else $error("wrong type code sent"); // RQ1

  property p_tx_rsv;
    O_TX_VALID && tx_idx_q == HDR_RSV |-> O_TX_BEAT.data == RSV_BYTE;
  endproperty
  a_tx_rsv: assert property (p_tx_rsv) else $error("reserved byte not zero"); // RQ21

  property p_tx_cnt;
    O_TX_VALID && tx_idx_q == HDR_CNT |-> O_TX_BEAT.data == TX_ENTRIES;
  endproperty
  a_tx_cnt: assert property (p_tx_cnt) else $error("entry count wrong"); // RQ1

  property p_tx_len;
    O_TX_VALID && O_TX_BEAT.last |-> tx_idx_q == TX_LAST_IDX;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("object not twelve bytes"); // RQ2

  property p_tx_hold;
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_BEAT);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("beat changed while stalled"); // RQ2

  property p_peer_dir;
    ent_done && is_dir |=> p_dir_q == ($past(ent_w[63:32]) & MASK_DIR);
  endproperty
  a_peer_dir: assert property (p_peer_dir) else $error("directory reserved bits kept"); // RQ5

  property p_peer_fctl;
    ent_done && is_fctl |=> p_fctl_q == ($past(ent_w[63:32]) & MASK_FCTL);
  endproperty
  a_peer_fctl: assert property (p_peer_fctl) else $error("controller reserved bits kept"); // RQ7

  property p_peer_cfg;
    ent_done && is_cfg |=> p_cfg_q == ($past(ent_w[63:32]) & MASK_CFG);
  endproperty
  a_peer_cfg: assert property (p_peer_cfg) else $error("config reserved bits kept"); // RQ10

  property p_peer_zone;
    ent_done && is_zone |=> p_zone_q == ($past(ent_w[63:32]) & MASK_ZONE);
  endproperty
  a_peer_zone: assert property (p_peer_zone) else $error("zoning word not taken"); // RQ20

  property p_vendor;
    ent_done && is_dir |=> p_dirv_q == $past(ent_w[31:0]);
  endproperty
  a_vendor: assert property (p_vendor) else $error("vendor word altered"); // RQ8
endmodule // capobj_codec

/* File: tb/capobj_peer.sv */
// far-side switch model: sinks transmitted objects and sources received ones
`timescale 1ns/100ps
module capobj_peer
  import capobj_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire beat_t i_tx_beat,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output beat_t o_rx_beat,
  output logic o_rx_valid
);
  logic stall = 1'b0;
  logic [8:0] got_q[$];

  initial begin
    o_tx_ready = 1'b0;
    o_rx_beat = '0;
    o_rx_valid = 1'b0;
  end

  // random stalls when asked, so every beat must stand until taken
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready && i_rst_n)
      got_q.push_back({i_tx_beat.last, i_tx_beat.data});
    o_tx_ready <= stall ? 1'($urandom % 2) : 1'b1;
  end

  task automatic put_byte(input logic [7:0] b, input logic lst);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_beat <= '{data: b, last: lst};
  endtask

  task automatic send_obj(input logic [7:0] t, input logic [7:0] s, input logic [7:0] cnt,
                          input logic [63:0] e0, input logic [63:0] e1);
    logic [63:0] e;
    put_byte(t, 1'b0);
    put_byte(s, 1'b0);
    put_byte(8'h00, 1'b0);
    put_byte(cnt, cnt == 8'h00);
    for (int i = 0; i < cnt; i++) begin
      e = (i == 0) ? e0 : e1;
      for (int j = 0; j < 8; j++)
        put_byte(e[63-8*j -: 8], (i == cnt - 1) && (j == 7));
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    // released line shows the inverse of its last value
    o_rx_beat <= ~o_rx_beat;
  endtask
endmodule // capobj_peer

/* File: tb/capobj_codec_bench.sv */
// self-checking bench for the capability object codec
`timescale 1ns/100ps
module capobj_codec_bench
  import capobj_pkg::*;
();
  logic clk, rst_n, wr, rd, tx_valid, tx_ready, rx_valid;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  beat_t tx_beat, rx_beat;
  peer_caps_t peer_caps;
  zone_flags_t peer_zone;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] type_tab [4] = '{8'hfc, 8'hfd, 8'hfa, 8'hfa};
  logic [7:0] sub_tab [4] = '{8'h02, 8'h00, 8'h01, 8'h03};
  logic [31:0] mask_tab [4] = '{32'h1f, 32'h1, 32'hf, 32'h3ff};
  logic [7:0] lflag_tab [4] = '{8'h04, 8'h0c, 8'h14, 8'h18};
  logic [7:0] lvend_tab [2] = '{8'h08, 8'h10};
  logic [7:0] pflag_tab [4] = '{8'h20, 8'h28, 8'h30, 8'h34};
  logic [7:0] pvend_tab [2] = '{8'h24, 8'h2c};
  logic [31:0] exp_flag [4];
  logic [31:0] exp_vend [2];

  capobj_codec dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_TX_BEAT(tx_beat), .O_TX_VALID(tx_valid),
    .I_TX_READY(tx_ready), .I_RX_BEAT(rx_beat), .I_RX_VALID(rx_valid),
    .O_PEER_CAPS(peer_caps), .O_PEER_ZONE(peer_zone));

  capobj_peer peer (.i_clk(clk), .i_rst_n(rst_n), .i_tx_beat(tx_beat), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_rx_beat(rx_beat), .o_rx_valid(rx_valid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask

  // expected transmitted byte i of the object for service s
  function automatic logic [7:0] tx_byte(int s, int i);
    logic [31:0] w;
    w = (i < 8) ? exp_flag[s] : ((s < 2) ? exp_vend[s] : 32'h0);
    case (i)
      0: return type_tab[s];
      1: return sub_tab[s];
      2: return 8'h00;
      3: return 8'h01;
      default: return w[31-8*((i-4)%4) -: 8];
    endcase
  endfunction

  task automatic wait_decode();
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    logic [31:0] f, v, d, pz;
    int k;
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(32'hb374ab51));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 8'h3c; a += 4)
      chk_rd(8'(a), 32'h0);
    for (int s = 0; s < 4; s++) begin
      f = $urandom;
      exp_flag[s] = f & mask_tab[s];
      wr_reg(lflag_tab[s], f);
      chk_rd(lflag_tab[s], exp_flag[s]);
      if (s < 2) begin
        exp_vend[s] = $urandom;
        wr_reg(lvend_tab[s], exp_vend[s]);
        chk_rd(lvend_tab[s], exp_vend[s]);
      end
    end
    for (int s = 0; s < 4; s++) begin
      peer.stall = s[0];
      peer.got_q.delete();
      wr_reg(REG_CTRL, {29'h0, 2'(s), 1'b1});
      if (s == 0) begin
        wr_reg(REG_CTRL, 32'h3);
        rd_reg(REG_STATUS, d);
        chk({31'h0, d[4]}, 32'h1);
      end
      k = 0;
      while (peer.got_q.size() < 12 && k < 400) begin
        @(posedge clk);
        k++;
      end
      repeat (20) @(posedge clk);
      chk(peer.got_q.size(), 32'd12);
      for (int i = 0; i < 12 && i < peer.got_q.size(); i++)
        chk({23'h0, peer.got_q[i]}, {23'h0, i == 11, tx_byte(s, i)});
    end
    for (int s = 0; s < 4; s++) begin
      f = $urandom;
      v = $urandom;
      peer.send_obj(type_tab[s], sub_tab[s], 8'h01, {f, v}, 64'h0);
      wait_decode();
      case (s)
        0: chk({27'h0, peer_caps.ns_zero_acc, peer_caps.ns_fmt}, f & 32'h1f);
        1: chk({31'h0, peer_caps.fc_rscn}, f & 32'h1);
        2: chk({28'h0, peer_caps.cfg_cls}, f & 32'hf);
        default: chk({22'h0, peer_zone}, f & 32'h3ff);
      endcase
      chk_rd(pflag_tab[s], f & mask_tab[s]);
      if (s < 2)
        chk_rd(pvend_tab[s], v);
    end
    pz = f & 32'h3ff;
    chk_rd(REG_STATUS, 32'hf);
    f = $urandom;
    v = $urandom;
    d = $urandom;
    peer.send_obj(8'hfc, 8'h02, 8'h02, {d, ~v}, {f, v});
    wait_decode();
    chk_rd(REG_P_DIR, f & 32'h1f);
    chk_rd(REG_P_DIRV, v);
    peer.send_obj(8'hfa, 8'h03, 8'h00, 64'h0, 64'h0);
    wait_decode();
    chk_rd(REG_P_ZONE, pz);
    peer.send_obj(8'hfa, 8'h02, 8'h01, {32'hffffffff, v}, 64'h0);
    wait_decode();
    chk_rd(REG_P_ZONE, pz);
    chk_rd(REG_STATUS, 32'h2f);
    wr_reg(REG_STATUS, 32'h20);
    chk_rd(REG_STATUS, 32'hf);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(REG_STATUS, 32'h0);
    chk({22'h0, peer_zone}, 32'h0);
    summarize();
  end
endmodule // capobj_codec_bench
